// ### rtl/iowd_top.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
// Function
// - claim only inside inclusive start..end range
// - two independent windows, same layout
// - start low byte at 08h, 0Ch
// - start high byte at 09h, 0Dh
// - end low byte at 0Ah, 0Eh
// - end high byte at 0Bh, 0Fh
// - card address is host plus offset, offset bit 0 ignored
// - offset high byte at 37h, 39h
// - window answers only while enable bit set
// - width from card indicator or size bit
module iowd_top (
   input  wire logic                      CLK,
   input  wire logic                      SYS_RST,
   input  wire logic [iowd_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                      S_AXI_AWVALID,
   output logic                           S_AXI_AWREADY,
   input  wire logic [31:0]               S_AXI_WDATA,
   input  wire logic [3:0]                S_AXI_WSTRB,
   input  wire logic                      S_AXI_WVALID,
   output logic                           S_AXI_WREADY,
   output logic [1:0]                     S_AXI_BRESP,
   output logic                           S_AXI_BVALID,
   input  wire logic                      S_AXI_BREADY,
   input  wire logic [iowd_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic                      S_AXI_ARVALID,
   output logic                           S_AXI_ARREADY,
   output logic [31:0]                    S_AXI_RDATA,
   output logic [1:0]                     S_AXI_RRESP,
   output logic                           S_AXI_RVALID,
   input  wire logic                      S_AXI_RREADY,
   input  wire logic                      IO_REQ,
   input  wire logic [15:0]               IO_ADDR,
   input  wire logic                      CARD_IO_WIDTH_INDICATOR_N,
   output logic                           IO_DONE,
   output logic                           IO_CLAIM,
   output logic                           IO_HIT_WIN,
   output logic [15:0]                    CARD_ADDR,
   output logic                           CARD_WIDE
);
   import iowd_pkg::*;

   // window configuration storage
   logic [7:0]  map_en_r;             // mapping enable, bits 7:6 kept
   logic [7:0]  win_ctl_r;            // window control
   logic [15:0] start_r [NUM_WIN];    // inclusive start per window
   logic [15:0] end_r   [NUM_WIN];    // inclusive end per window
   logic [15:0] off_r   [NUM_WIN];    // card offset per window

   // write channel state
   logic        awready_r;            // address slot free
   logic        aw_full_r;            // address held
   logic [5:0]  aw_idx_r;             // held register index
   logic        wready_r;             // data slot free
   logic        w_full_r;             // data held
   logic [7:0]  wdata_r;              // held low byte
   logic        wlane_r;              // held strobe of byte lane 0
   logic        bvalid_r;             // write answer pending
   logic [1:0]  bresp_r;              // write answer code
   logic        wr_go;                // both halves present, do the write

   // read channel state
   logic        arready_r;            // read slot free
   logic        rvalid_r;             // read answer pending
   logic [31:0] rdata_r;              // read answer data
   logic [1:0]  rresp_r;              // read answer code
   logic [7:0]  rd_val;               // decoded read value
   logic        rd_ok;                // read index mapped

   // card width indicator synchroniser
   logic        ind_meta_r;           // first stage, read only by second
   logic        ind_sync_r;           // safe copy, low means 16-bit card

   // host cycle result
   logic        done_r;               // result strobe
   logic        claim_r;              // cycle claimed
   logic        win_r;                // claiming window
   logic [15:0] card_addr_r;          // translated address
   logic        wide_r;               // 16-bit data path
   logic        last_claim_r;         // sticky copy for status
   logic        last_win_r;           // sticky copy for status
   logic        last_wide_r;          // sticky copy for status

   // per window decode outputs
   logic [NUM_WIN-1:0] en_w;          // enable per window
   logic [NUM_WIN-1:0] hit_w;         // range hit per window
   logic [15:0]        card_w [NUM_WIN]; // translated address per window
   logic [NUM_WIN-1:0] wide_w;        // resolved width per window

   // enable bits for the two windows
   assign en_w[0] = map_en_r[MAP_EN_W0_BIT];
   assign en_w[1] = map_en_r[MAP_EN_W1_BIT];

   // width: card indicator under auto-size, else the size bit
   assign wide_w[0] = win_ctl_r[CTL_W0_AUTO_BIT] ? ~ind_sync_r
                    : win_ctl_r[CTL_W0_SIZE_BIT];
   assign wide_w[1] = win_ctl_r[CTL_W1_AUTO_BIT] ? ~ind_sync_r
                    : win_ctl_r[CTL_W1_SIZE_BIT];

   // one identical decoder per window
   generate
      for (genvar g = 0; g < NUM_WIN; g++) begin : g_win
         iowd_window u_win (
            .en         (en_w[g]),
            .host_addr  (IO_ADDR),
            .start_addr (start_r[g]),
            .end_addr   (end_r[g]),
            .offset     (off_r[g]),
            .hit        (hit_w[g]),
            .card_addr  (card_w[g])
         );
      end
   endgenerate

   // card pin crosses two flops before any logic sees it
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ind_meta_r <= 1'b1;
         ind_sync_r <= 1'b1;
      end else begin
         ind_meta_r <= CARD_IO_WIDTH_INDICATOR_N;
         ind_sync_r <= ind_meta_r;
      end
   end

   // host cycle: decide one cycle after the request
   // window 0 wins when both ranges overlap; software should avoid it
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         done_r      <= 1'b0;
         claim_r     <= 1'b0;
         win_r       <= 1'b0;
         card_addr_r <= REG16_RST;
         wide_r      <= 1'b0;
      end else begin
         done_r <= IO_REQ;
         if (IO_REQ) begin
            claim_r <= |hit_w;
            if (hit_w[0]) begin
               win_r       <= 1'b0;
               card_addr_r <= card_w[0];
               wide_r      <= wide_w[0];
            end else if (hit_w[1]) begin
               win_r       <= 1'b1;
               card_addr_r <= card_w[1];
               wide_r      <= wide_w[1];
            end else begin
               // a miss leaves no stale address on the card side
               win_r       <= 1'b0;
               card_addr_r <= REG16_RST;
               wide_r      <= 1'b0;
            end
         end
      end
   end

   // status copy of the latest decision, taken while IO_DONE is high and kept until the next IO_DONE
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         last_claim_r <= 1'b0;
         last_win_r   <= 1'b0;
         last_wide_r  <= 1'b0;
      end else if (done_r) begin
         last_claim_r <= claim_r;
         last_win_r   <= win_r;
         last_wide_r  <= wide_r;
      end
   end

   // write goes ahead once address and data are both held
   assign wr_go = aw_full_r && w_full_r && !bvalid_r;

   // write address channel; slot reopens after the answer is taken
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         awready_r <= 1'b1;
         aw_full_r <= 1'b0;
         aw_idx_r  <= 6'h00;
      end else begin
         if (S_AXI_AWVALID && awready_r) begin
            awready_r <= 1'b0;
            aw_full_r <= 1'b1;
            aw_idx_r  <= S_AXI_AWADDR[IDX_LSB +: 6];
         end else if (bvalid_r && S_AXI_BREADY) begin
            awready_r <= 1'b1;
         end
         if (wr_go) begin
            aw_full_r <= 1'b0;
         end
      end
   end

   // write data channel; only the low byte carries register data
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         wready_r <= 1'b1;
         w_full_r <= 1'b0;
         wdata_r  <= REG8_RST;
         wlane_r  <= 1'b0;
      end else begin
         if (S_AXI_WVALID && wready_r) begin
            wready_r <= 1'b0;
            w_full_r <= 1'b1;
            wdata_r  <= S_AXI_WDATA[7:0];
            wlane_r  <= S_AXI_WSTRB[0];
         end else if (bvalid_r && S_AXI_BREADY) begin
            wready_r <= 1'b1;
         end
         if (wr_go) begin
            w_full_r <= 1'b0;
         end
      end
   end

   // write answer; an unknown index gets a slave error
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   // index decode shared by read and write
   function automatic logic is_mapped(input logic [5:0] idx);
      logic ok;
      ok = 1'b0;
      case (idx)
         IDX_MAP_EN, IDX_WIN_CTL, IDX_STATUS: ok = 1'b1;
         IDX_W0_START_LO, IDX_W0_START_HI: ok = 1'b1;
         IDX_W0_END_LO, IDX_W0_END_HI: ok = 1'b1;
         IDX_W1_START_LO, IDX_W1_START_HI: ok = 1'b1;
         IDX_W1_END_LO, IDX_W1_END_HI: ok = 1'b1;
         IDX_W0_OFF_LO, IDX_W0_OFF_HI: ok = 1'b1;
         IDX_W1_OFF_LO, IDX_W1_OFF_HI: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // register writes; lane 0 must be strobed, status is read only
   // offset bit 0 is stored as written; the adder never uses it
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         map_en_r  <= REG8_RST;
         win_ctl_r <= REG8_RST;
         for (int i = 0; i < NUM_WIN; i++) begin
            start_r[i] <= REG16_RST;
            end_r[i]   <= REG16_RST;
            off_r[i]   <= REG16_RST;
         end
      end else if (wr_go && wlane_r) begin
         case (aw_idx_r)
            IDX_MAP_EN:      map_en_r <= wdata_r & MAP_EN_MASK;
            IDX_WIN_CTL:     win_ctl_r <= wdata_r;
            IDX_W0_START_LO: start_r[0][7:0] <= wdata_r;
            IDX_W1_START_LO: start_r[1][7:0] <= wdata_r;
            IDX_W0_START_HI: start_r[0][15:8] <= wdata_r;
            IDX_W1_START_HI: start_r[1][15:8] <= wdata_r;
            IDX_W0_END_LO:   end_r[0][7:0] <= wdata_r;
            IDX_W1_END_LO:   end_r[1][7:0] <= wdata_r;
            IDX_W0_END_HI:   end_r[0][15:8] <= wdata_r;
            IDX_W1_END_HI:   end_r[1][15:8] <= wdata_r;
            IDX_W0_OFF_LO:   off_r[0][7:0] <= wdata_r;
            IDX_W1_OFF_LO:   off_r[1][7:0] <= wdata_r;
            IDX_W0_OFF_HI:   off_r[0][15:8] <= wdata_r;
            IDX_W1_OFF_HI:   off_r[1][15:8] <= wdata_r;
            default: ;
         endcase
      end
   end

   // read decode from the incoming address
   always_comb begin
      rd_val = REG8_RST;
      rd_ok  = is_mapped(S_AXI_ARADDR[IDX_LSB +: 6]);
      case (S_AXI_ARADDR[IDX_LSB +: 6])
         IDX_MAP_EN:      rd_val = map_en_r;
         IDX_WIN_CTL:     rd_val = win_ctl_r;
         IDX_W0_START_LO: rd_val = start_r[0][7:0];
         IDX_W0_START_HI: rd_val = start_r[0][15:8];
         IDX_W0_END_LO:   rd_val = end_r[0][7:0];
         IDX_W0_END_HI:   rd_val = end_r[0][15:8];
         IDX_W1_START_LO: rd_val = start_r[1][7:0];
         IDX_W1_START_HI: rd_val = start_r[1][15:8];
         IDX_W1_END_LO:   rd_val = end_r[1][7:0];
         IDX_W1_END_HI:   rd_val = end_r[1][15:8];
         IDX_W0_OFF_LO:   rd_val = off_r[0][7:0];
         IDX_W0_OFF_HI:   rd_val = off_r[0][15:8];
         IDX_W1_OFF_LO:   rd_val = off_r[1][7:0];
         IDX_W1_OFF_HI:   rd_val = off_r[1][15:8];
         // live indicator, then sticky last width, window, claim
         IDX_STATUS: rd_val = {4'h0, ~ind_sync_r, last_wide_r,
                               last_win_r, last_claim_r};
         default:         rd_val = REG8_RST;
      endcase
   end

   // read channel; one read in flight, answer the cycle after taking
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= RESP_OKAY;
      end else if (S_AXI_ARVALID && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= {24'h00_0000, rd_val};
         rresp_r   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && S_AXI_RREADY) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   // outputs, all from flops
   assign S_AXI_AWREADY = awready_r;
   assign S_AXI_WREADY  = wready_r;
   assign S_AXI_BVALID  = bvalid_r;
   assign S_AXI_BRESP   = bresp_r;
   assign S_AXI_ARREADY = arready_r;
   assign S_AXI_RVALID  = rvalid_r;
   assign S_AXI_RDATA   = rdata_r;
   assign S_AXI_RRESP   = rresp_r;
   assign IO_DONE       = done_r;
   assign IO_CLAIM      = claim_r;
   assign IO_HIT_WIN    = win_r;
   assign CARD_ADDR     = card_addr_r;
   assign CARD_WIDE     = wide_r;

   // checks on the decode and register paths
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   // a window 0 claim lay inside its range while enabled
   a_claim_w0_range: assert property (
      IO_DONE && IO_CLAIM && !IO_HIT_WIN |->
         $past(IO_ADDR) >= $past(start_r[0]) &&
         $past(IO_ADDR) <= $past(end_r[0]) && $past(en_w[0]))
      else $error("window 0 claim outside its range");

   // a window 1 claim lay inside its own range while enabled
   a_claim_w1_range: assert property (
      IO_DONE && IO_CLAIM && IO_HIT_WIN |->
         $past(IO_ADDR) >= $past(start_r[1]) &&
         $past(IO_ADDR) <= $past(end_r[1]) && $past(en_w[1]))
      else $error("window 1 claim outside its range");

   // with both enables off no request is claimed
   a_no_claim_off: assert property (
      IO_REQ && !en_w[0] && !en_w[1] |=> IO_DONE && !IO_CLAIM)
      else $error("claim while both windows disabled");

   // window 0 card address is host address plus its offset above bit 0
   a_translate_sum: assert property (
      IO_DONE && IO_CLAIM && !IO_HIT_WIN |->
         CARD_ADDR[15:1] == 15'($past(IO_ADDR[15:1]) +
                               $past(off_r[0][15:1])))
      else $error("card address not host plus offset");

   // bit 0 passes straight through on any claim
   a_bit0_pass: assert property (
      IO_DONE && IO_CLAIM |-> CARD_ADDR[0] == $past(IO_ADDR[0]))
      else $error("card address bit 0 altered");

   // window 0 width follows the indicator under auto-size
   a_width_auto: assert property (
      IO_REQ && hit_w[0] && win_ctl_r[CTL_W0_AUTO_BIT] |=>
         CARD_WIDE == !$past(ind_sync_r))
      else $error("auto width ignores card indicator");

   // start low byte of window 1 stored, high byte untouched
   a_start_lo_rb: assert property (
      wr_go && wlane_r && aw_idx_r == IDX_W1_START_LO |=>
         start_r[1][7:0] == $past(wdata_r) &&
         start_r[1][15:8] == $past(start_r[1][15:8]))
      else $error("start low byte not stored");

   // start high byte of window 1 lands in the top byte
   a_start_hi_st: assert property (
      wr_go && wlane_r && aw_idx_r == IDX_W1_START_HI |=>
         start_r[1][15:8] == $past(wdata_r) &&
         start_r[1][7:0] == $past(start_r[1][7:0]))
      else $error("start high byte misplaced");

   // end low byte of window 1 stored, high byte untouched
   a_end_lo_st: assert property (
      wr_go && wlane_r && aw_idx_r == IDX_W1_END_LO |=>
         end_r[1][7:0] == $past(wdata_r) &&
         end_r[1][15:8] == $past(end_r[1][15:8]))
      else $error("end low byte misplaced");

   // end high byte of window 0 stored, window 1 untouched
   a_end_hi_st: assert property (
      wr_go && wlane_r && aw_idx_r == IDX_W0_END_HI |=>
         end_r[0][15:8] == $past(wdata_r) &&
         end_r[1] == $past(end_r[1]))
      else $error("end high byte misplaced");

   // offset high byte of window 1 stored at its index
   a_off_hi_st: assert property (
      wr_go && wlane_r && aw_idx_r == IDX_W1_OFF_HI |=>
         off_r[1][15:8] == $past(wdata_r) &&
         off_r[0] == $past(off_r[0]))
      else $error("offset high byte misplaced");

   // a write answer holds until it is taken
   a_bvalid_hold: assert property (
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID [*1])
      else $error("write answer dropped early");

   // main scenarios
   c_claim_w0: cover property (IO_DONE && IO_CLAIM && !IO_HIT_WIN);
   c_claim_w1: cover property (IO_DONE && IO_CLAIM && IO_HIT_WIN);
   c_miss:     cover property (IO_DONE && !IO_CLAIM);
   c_write:    cover property (S_AXI_BVALID && S_AXI_BREADY);
   c_read:     cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule

// ### rtl/iowd_pkg.sv
package iowd_pkg;
   // register indexes; byte address on the bus is four times the index
   localparam logic [5:0] IDX_MAP_EN      = 6'h06;
   localparam logic [5:0] IDX_WIN_CTL     = 6'h07;
   localparam logic [5:0] IDX_W0_START_LO = 6'h08;
   localparam logic [5:0] IDX_W0_START_HI = 6'h09;
   localparam logic [5:0] IDX_W0_END_LO   = 6'h0A;
   localparam logic [5:0] IDX_W0_END_HI   = 6'h0B;
   localparam logic [5:0] IDX_W1_START_LO = 6'h0C;
   localparam logic [5:0] IDX_W1_START_HI = 6'h0D;
   localparam logic [5:0] IDX_W1_END_LO   = 6'h0E;
   localparam logic [5:0] IDX_W1_END_HI   = 6'h0F;
   localparam logic [5:0] IDX_W0_OFF_LO   = 6'h36;
   localparam logic [5:0] IDX_W0_OFF_HI   = 6'h37;
   localparam logic [5:0] IDX_W1_OFF_LO   = 6'h38;
   localparam logic [5:0] IDX_W1_OFF_HI   = 6'h39;
   localparam logic [5:0] IDX_STATUS      = 6'h3A;

   // bus address width and index field position
   localparam int ADDR_W   = 8;
   localparam int IDX_LSB  = 2;

   // mapping enable fields
   localparam int MAP_EN_W0_BIT = 6;
   localparam int MAP_EN_W1_BIT = 7;
   localparam logic [7:0] MAP_EN_MASK = 8'hC0;

   // window control fields
   localparam int CTL_W0_SIZE_BIT = 0;
   localparam int CTL_W0_AUTO_BIT = 1;
   localparam int CTL_W1_SIZE_BIT = 4;
   localparam int CTL_W1_AUTO_BIT = 5;

   // reset values
   localparam logic [7:0]  REG8_RST  = 8'h00;
   localparam logic [15:0] REG16_RST = 16'h0000;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // number of host windows per socket
   localparam int NUM_WIN = 2;
endpackage

// ### rtl/iowd_window.sv
`timescale 1ns/1ps
// one host I/O window: inclusive range compare and card address forming
module iowd_window (
   input  wire logic        en,
   input  wire logic [15:0] host_addr,
   input  wire logic [15:0] start_addr,
   input  wire logic [15:0] end_addr,
   input  wire logic [15:0] offset,
   output logic             hit,
   output logic [15:0]      card_addr
);
   import iowd_pkg::*;

   // claim only inside [start, end] and only while enabled
   assign hit = en && (host_addr >= start_addr)
                   && (host_addr <= end_addr);

   // add the offset above bit 0; the sum wraps in 15 bits
   assign card_addr[15:1] = host_addr[15:1] + offset[15:1];
   // offset bit 0 is ignored, so host bit 0 passes straight through
   assign card_addr[0] = host_addr[0];
endmodule

// ### testbench/iowd_card_model.sv
`timescale 1ns/1ps
// inserted card: reports its i/o width on the active-low indicator pin
module iowd_card_model (
   input  wire logic CLK,
   input  wire logic SAYS_WIDE,
   output logic      IND_N
);
   // registered so the pin moves off the edge, like a real card's decode
   always_ff @(posedge CLK) begin
      IND_N <= ~SAYS_WIDE;
   end
endmodule

// ### testbench/io_window_decode_translate_tb_top.sv
`timescale 1ns/1ps
module io_window_decode_translate_tb_top;
   import iowd_pkg::*;
   logic        clk, rst, awv, wv, br, arv, rr, req, wide;
   logic [7:0]  awa, ara;
   logic [31:0] wd;
   logic [15:0] ioa;
   wire         awr, wr_rdy, bv, arr, rv, ind_n, io_done, io_claim, io_win;
   wire         card_wide;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [15:0]  card_addr;
   int          bad_count, samples_checked;
   logic [31:0] q;
   logic [1:0]  rs;
   logic [3:0]  strb;

   always #12.5 clk = ~clk;  // 40 MHz

   iowd_top dut (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rr), .IO_REQ(req), .IO_ADDR(ioa),
      .CARD_IO_WIDTH_INDICATOR_N(ind_n), .IO_DONE(io_done),
      .IO_CLAIM(io_claim), .IO_HIT_WIN(io_win), .CARD_ADDR(card_addr),
      .CARD_WIDE(card_wide));
   iowd_card_model card (.CLK(clk), .SAYS_WIDE(wide), .IND_N(ind_n));

   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // case equality so an unknown never counts as a match
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask

   // a wait that runs out is a failure and ends the run
   task automatic tmo(input logic ok);
      if (ok !== 1'b1) begin
         bad_count++;
         $display("mismatch at %0t: bus answer timed out", $time);
         complete_run;
      end
   endtask

   // register write; each channel dropped at its own handshake
   task automatic wr(input logic [5:0] i, input logic [7:0] d,
                     input logic [1:0] e);
      int n;
      n = 0;
      awa <= {i, 2'h0};
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awr) awv <= 1'b0;
         if (wr_rdy) wv <= 1'b0;
      end while (!bv && n < 40);
      tmo(bv);
      chk(bresp, e);
      br <= 1'b0;
      @(posedge clk);  // keeps bready from two writes in one step
   endtask

   // register read; data and response handed back to the caller
   task automatic rd(input logic [5:0] i);
      int n;
      n = 0;
      ara <= {i, 2'h0};
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arr) arv <= 1'b0;
      end while (!rv && n < 40);
      tmo(rv);
      q = rdata;
      rs = rresp;
      rr <= 1'b0;
      @(posedge clk);
   endtask

   // one host i/o cycle; result is due exactly one edge later
   task automatic io(input logic [15:0] a, input logic c, input logic w,
                     input logic [15:0] ca, input logic wdth);
      req <= 1'b1;
      ioa <= a;
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      chk({io_done, io_claim, io_win, card_wide}, {1'b1, c, w, wdth});
      chk(card_addr, ca);
   endtask

   // program start, end and offset of one window; offset kept even
   task automatic setw(input logic w, input logic [15:0] s,
                       input logic [15:0] e, input logic [15:0] o);
      logic [5:0] b, f;
      b = w ? IDX_W1_START_LO : IDX_W0_START_LO;
      f = w ? IDX_W1_OFF_LO : IDX_W0_OFF_LO;
      wr(b, s[7:0], RESP_OKAY);
      wr(b + 6'h1, s[15:8], RESP_OKAY);
      wr(b + 6'h2, e[7:0], RESP_OKAY);
      wr(b + 6'h3, e[15:8], RESP_OKAY);
      wr(f, {o[7:1], 1'b0}, RESP_OKAY);
      wr(f + 6'h1, o[15:8], RESP_OKAY);
   endtask

   // reset value, then own pattern back, for every start, end and offset register
   task automatic t_regs;
      logic [5:0] idx [12];
      idx = '{6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
              6'h36, 6'h37, 6'h38, 6'h39};
      foreach (idx[k]) begin
         rd(idx[k]);
         chk(q, 32'h0);
         wr(idx[k], {2'h2, idx[k]}, RESP_OKAY);
         rd(idx[k]);
         chk(q, {24'h0, 2'h2, idx[k]});
         chk({30'h0, rs}, {30'h0, RESP_OKAY});
      end
      rd(6'h3C);
      chk(q, 32'h0);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      wr(6'h3C, 8'h5A, RESP_SLVERR);
      // lane 0 not strobed: answered but nothing stored
      strb <= 4'hE;
      wr(IDX_W0_START_LO, 8'h55, RESP_OKAY);
      strb <= 4'hF;
      rd(IDX_W0_START_LO);
      chk(q, 32'h0000_0088);
      // only the two window enable bits are kept
      wr(IDX_MAP_EN, 8'hFF, RESP_OKAY);
      rd(IDX_MAP_EN);
      chk(q, {24'h0, MAP_EN_MASK});
      $display("register test done");
   endtask

   // inclusive bounds, enable gating and offset addition on window 0
   task automatic t_decode;
      // no window range ever covers 3E0h or 3E1h
      setw(1'b0, 16'h0300, 16'h031F, 16'h1000);
      setw(1'b1, 16'h0000, 16'h0000, 16'h0000);
      wr(IDX_MAP_EN, 8'h00, RESP_OKAY);
      io(16'h0300, 1'b0, 1'b0, 16'h0000, 1'b0);
      wr(IDX_MAP_EN, 8'h40, RESP_OKAY);
      io(16'h02FF, 1'b0, 1'b0, 16'h0000, 1'b0);
      io(16'h0300, 1'b1, 1'b0, 16'h1300, 1'b0);
      io(16'h031F, 1'b1, 1'b0, 16'h131F, 1'b0);
      io(16'h0320, 1'b0, 1'b0, 16'h0000, 1'b0);
      $display("decode test done");
   endtask

   // second window beside the first, then on its own, with a sum that wraps past ffff
   task automatic t_wrap;
      setw(1'b1, 16'h0400, 16'h040F, 16'hFF00);
      wr(IDX_MAP_EN, 8'hC0, RESP_OKAY);
      io(16'h0401, 1'b1, 1'b1, 16'h0301, 1'b0);
      io(16'h0310, 1'b1, 1'b0, 16'h1310, 1'b0);
      wr(IDX_MAP_EN, 8'h80, RESP_OKAY);
      io(16'h0310, 1'b0, 1'b0, 16'h0000, 1'b0);
      io(16'h040F, 1'b1, 1'b1, 16'h030F, 1'b0);
      $display("wrap test done");
   endtask

   // size bit, then auto-size following the card's indicator
   task automatic t_width;
      wr(IDX_MAP_EN, 8'h40, RESP_OKAY);
      wr(IDX_WIN_CTL, 8'h01, RESP_OKAY);
      io(16'h0305, 1'b1, 1'b0, 16'h1305, 1'b1);
      wr(IDX_WIN_CTL, 8'h03, RESP_OKAY);
      repeat (5) @(posedge clk);  // indicator passes two sync flops
      io(16'h0305, 1'b1, 1'b0, 16'h1305, 1'b0);
      wide <= 1'b1;
      repeat (5) @(posedge clk);
      io(16'h0306, 1'b1, 1'b0, 16'h1306, 1'b1);
      // window 1: size bit, then auto-size against a clear size bit
      wr(IDX_MAP_EN, 8'h80, RESP_OKAY);
      wr(IDX_WIN_CTL, 8'h10, RESP_OKAY);
      io(16'h0402, 1'b1, 1'b1, 16'h0302, 1'b1);
      wr(IDX_WIN_CTL, 8'h20, RESP_OKAY);
      io(16'h0403, 1'b1, 1'b1, 16'h0303, 1'b1);
      // status: indicator set, last cycle wide, window 1, claimed
      rd(IDX_STATUS);
      chk(q, 32'h0000_000F);
      chk({30'h0, rs}, {30'h0, RESP_OKAY});
      $display("width test done");
   endtask

   initial begin
      {clk, awv, wv, br, arv, rr, req, wide} = '0;
      {awa, ara, wd, ioa} = '0;
      strb = 4'hF;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_decode;
      t_wrap;
      t_width;
      complete_run;
   end
endmodule
